// >>> hdl/cdrsw_defs.svh
// constants for the selective-wake clock recovery block
// assumes a 100 MHz clock and an Avalon-MM register port
`ifndef CDRSW_DEFS_SVH
`define CDRSW_DEFS_SVH

// register byte offsets
`define CDRSW_OFS_CTRL_A 8'h00
`define CDRSW_OFS_CTRL_B 8'h04
`define CDRSW_OFS_QUANTA 8'h08
`define CDRSW_OFS_SAMPLE 8'h0c
`define CDRSW_OFS_UPPER 8'h10
`define CDRSW_OFS_LOWER 8'h14
`define CDRSW_OFS_MODE 8'h18
`define CDRSW_OFS_STATUS 8'h1c
`define CDRSW_OFS_BITTIME 8'h20

// field positions
`define CDRSW_A_EN 0
`define CDRSW_A_FLT_LO 1
`define CDRSW_A_FLT_HI 2
`define CDRSW_MODE_XCVR_LO 0
`define CDRSW_MODE_XCVR_HI 2
`define CDRSW_MODE_FD 3
`define CDRSW_MODE_RXSEL 4
`define CDRSW_MODE_ERRDIS 5
`define CDRSW_MODE_GLITCH 6
`define CDRSW_MODE_STOP 7

// reset values
`define CDRSW_RST_SAMPLE 6'h33
`define CDRSW_RST_QUANTA 8'h0a
`define CDRSW_RST_UPPER 8'h0c
`define CDRSW_RST_LOWER 8'h08
`define CDRSW_XCVR_OFF 3'h0

// timing
`define CDRSW_CLK_MHZ 100
`define CDRSW_SILENCE_MS 600
`define CDRSW_SILENCE_CYC (`CDRSW_SILENCE_MS * 1000 * `CDRSW_CLK_MHZ)
`define CDRSW_WAKE_US 100
`define CDRSW_WAKE_CYC (`CDRSW_WAKE_US * `CDRSW_CLK_MHZ)
`define CDRSW_BIT_MIN_US 1
`define CDRSW_BIT_MIN_CYC (`CDRSW_BIT_MIN_US * `CDRSW_CLK_MHZ)
// glitch limits in tenths of a percent, then the top arbitration rate in kbit/s
`define CDRSW_GL2_PM 50
`define CDRSW_DOM2_PM 175
`define CDRSW_GL5_PM 25
`define CDRSW_DOM5_PM 88
`define CDRSW_MAX_ARB_KBPS 500

`endif

// >>> hdl/cdrsw_pkg.sv
// types for the selective-wake clock recovery block
// constants live in cdrsw_defs.svh
package cdrsw_pkg;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } cdrsw_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } cdrsw_rsp_t;

  typedef struct packed {
    logic wake;
    logic bus_idle;
    logic interrupt_out_n;
    logic supply_on;
  } cdrsw_evt_t;
endpackage

// >>> hdl/cdrsw_filter.sv
// dominant pulse filter for the fd tolerant path
// assumes a synchronised rx level and a bit length in clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "cdrsw_defs.svh"
module cdrsw_filter (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic rx_dom_i, // dominant level
  input wire logic strict_i, // 5 Mbit/s thresholds
  input wire logic [15:0] bit_cyc_i, // arbitration bit in cycles
  output logic dom_o // qualified dominant
);
  typedef struct packed {
    logic [15:0] cnt;
    logic dom;
  } cdrsw_flt_t;
  cdrsw_flt_t st, next_st;
  logic [25:0] need;

  // -------------------------------------------------------------
  // thresholds scaled from the arbitration bit time
  // -------------------------------------------------------------
  always_comb begin
    if (strict_i) begin
      need = 26'(({10'h000, bit_cyc_i} * 26'(`CDRSW_DOM5_PM)) / 26'd1000);
    end else begin
      need = 26'(({10'h000, bit_cyc_i} * 26'(`CDRSW_DOM2_PM)) / 26'd1000);
    end
  end

  always_comb begin
    next_st = st;
    if (rx_dom_i) begin
      if (st.cnt != 16'hffff) begin
        next_st.cnt = st.cnt + 16'h0001;
      end
      // short pulses below the threshold never reach dom
      if ({10'h000, st.cnt} >= need) begin
        next_st.dom = 1'b1;
      end
    end else begin
      next_st.cnt = 16'h0000;
      next_st.dom = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dom_o = st.dom;
endmodule
`default_nettype wire

// >>> hdl/cdrsw_top.sv
// selective-wake clock recovery, silence timer and wake signalling
// assumes an Avalon-MM master on the clock and an async rx pin
`timescale 1ns/1ps
`default_nettype none
`include "cdrsw_defs.svh"

module cdrsw_top #(
  parameter int unsigned SILENCE_CYC = `CDRSW_SILENCE_CYC
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire cdrsw_pkg::cdrsw_req_t req_i, // bus request
  output cdrsw_pkg::cdrsw_rsp_t rsp_o, // bus answer
  input wire logic rx_i, // can rx pin, low = dominant
  input wire logic wake_det_i, // valid pattern or frame end
  input wire logic fdf_det_i, // fdf bit seen in frame
  output logic interrupt_out_n_o, // wake interrupt, low active
  output logic supply_on_o, // main supply request
  output logic bus_idle_o, // silence timeout reached
  output logic [15:0] bit_cyc_o // recovered bit length
);
  import cdrsw_pkg::*;

  typedef struct packed {
    logic [1:0] rx_sync;
    logic rx_prev;
    logic [2:0] ctrl_a;
    logic [1:0] osc_clock_select;
    logic [7:0] quanta;
    logic [5:0] sample_point;
    logic [7:0] upper;
    logic [7:0] lower;
    logic [7:0] mode;
    logic [15:0] bit_cyc;
    logic [15:0] edge_cnt;
    logic [31:0] silence_cnt;
    logic [15:0] wake_cnt;
    logic wake_pend;
    logic fdf_seen;
    logic reloads;
    cdrsw_rsp_t rsp;
    cdrsw_evt_t evt;
  } cdrsw_state_t;

  cdrsw_state_t st, next_st;
  logic dom_q;
  logic fd_active;
  logic edge_seen_w;

  // quanta times clock-select scale gives cycles per bit
  function automatic logic [15:0] base_bit(input logic [7:0] q,
                                           input logic [1:0] sel);
    base_bit = 16'({8'h00, q} << sel);
  endfunction

  function automatic logic [31:0] rd_mux(input cdrsw_state_t s,
                                         input logic [7:0] a);
    rd_mux = 32'h0000_0000;
    case (a)
      `CDRSW_OFS_CTRL_A: rd_mux = {29'h0, s.ctrl_a};
      `CDRSW_OFS_CTRL_B: rd_mux = {30'h0, s.osc_clock_select};
      `CDRSW_OFS_QUANTA: rd_mux = {24'h0, s.quanta};
      `CDRSW_OFS_SAMPLE: rd_mux = {26'h0, s.sample_point};
      `CDRSW_OFS_UPPER: rd_mux = {24'h0, s.upper};
      `CDRSW_OFS_LOWER: rd_mux = {24'h0, s.lower};
      `CDRSW_OFS_MODE: rd_mux = {24'h0, s.mode};
      `CDRSW_OFS_STATUS: rd_mux = {28'h0, s.reloads, s.fdf_seen,
                                   s.evt.bus_idle, s.evt.wake};
      `CDRSW_OFS_BITTIME: rd_mux = {16'h0, s.bit_cyc};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // -------------------------------------------------------------
  // fd tolerant filter
  // -------------------------------------------------------------
  assign fd_active = st.mode[`CDRSW_MODE_FD] &
                     st.mode[`CDRSW_MODE_RXSEL] & ~st.fdf_seen;

  cdrsw_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx_dom_i(~st.rx_sync[1]),
    .strict_i(st.mode[`CDRSW_MODE_GLITCH]),
    .bit_cyc_i(st.bit_cyc),
    .dom_o(dom_q)
  );

  always_comb begin
    logic dom_now;
    logic edge_seen;
    logic [15:0] lim_hi;
    logic [15:0] lim_lo;
    logic [15:0] base;
    dom_now = 1'b0;
    edge_seen = 1'b0;
    lim_hi = 16'h0000;
    lim_lo = 16'h0000;
    base = 16'h0000;
    next_st = st;
    next_st.rx_sync = {st.rx_sync[0], rx_i};
    next_st.rsp.waitrequest = 1'b1;

    // -----------------------------------------------------------
    // register port, one wait cycle per access
    // -----------------------------------------------------------
    if ((req_i.read | req_i.write) & st.rsp.waitrequest) begin
      next_st.rsp.waitrequest = 1'b0;
      next_st.rsp.readdata = rd_mux(st, req_i.address);
      if (req_i.write) begin
        case (req_i.address)
          `CDRSW_OFS_CTRL_A: next_st.ctrl_a = req_i.writedata[2:0];
          `CDRSW_OFS_CTRL_B: next_st.osc_clock_select = req_i.writedata[1:0];
          `CDRSW_OFS_QUANTA: next_st.quanta = req_i.writedata[7:0];
          `CDRSW_OFS_SAMPLE: next_st.sample_point = req_i.writedata[5:0];
          `CDRSW_OFS_UPPER: next_st.upper = req_i.writedata[7:0];
          `CDRSW_OFS_LOWER: next_st.lower = req_i.writedata[7:0];
          `CDRSW_OFS_MODE: next_st.mode = req_i.writedata[7:0];
          `CDRSW_OFS_STATUS: begin
            // write one to clear the sticky bits
            if (req_i.writedata[0]) next_st.evt.wake = 1'b0;
            if (req_i.writedata[2]) next_st.fdf_seen = 1'b0;
            if (req_i.writedata[3]) next_st.reloads = 1'b0;
          end
          default: begin
          end
        endcase
      end
    end

    // -----------------------------------------------------------
    // clock recovery
    // -----------------------------------------------------------
    dom_now = fd_active ? dom_q : ~st.rx_sync[1];
    next_st.rx_prev = dom_now;
    // both transitions count, so one-bit gaps reach the tracker
    edge_seen = dom_now ^ st.rx_prev;
    base = base_bit(st.quanta, st.osc_clock_select);
    lim_hi = base_bit(st.upper, st.osc_clock_select);
    lim_lo = base_bit(st.lower, st.osc_clock_select);
    if (st.edge_cnt != 16'hffff) next_st.edge_cnt = st.edge_cnt + 16'h0001;
    if (!st.ctrl_a[`CDRSW_A_EN]) begin
      next_st.bit_cyc = base;
    end else if (edge_seen) begin
      next_st.edge_cnt = 16'h0000;
      // one bit gap: nudge towards the measured length
      if (st.edge_cnt < st.bit_cyc + (st.bit_cyc >> 1) &&
          st.edge_cnt > (st.bit_cyc >> 1)) begin
        if (st.edge_cnt > st.bit_cyc) next_st.bit_cyc = st.bit_cyc + 16'h0001;
        else if (st.edge_cnt < st.bit_cyc) next_st.bit_cyc = st.bit_cyc - 16'h0001;
      end
    end
    if (st.ctrl_a[`CDRSW_A_EN] &&
        (st.bit_cyc >= lim_hi || st.bit_cyc <= lim_lo)) begin
      next_st.bit_cyc = base;
      next_st.edge_cnt = 16'h0000;
      next_st.reloads = 1'b1;
    end
    if (next_st.bit_cyc < 16'(`CDRSW_BIT_MIN_CYC)) begin
      next_st.bit_cyc = 16'(`CDRSW_BIT_MIN_CYC);
    end

    if (fdf_det_i & fd_active) next_st.fdf_seen = 1'b1;

    // -----------------------------------------------------------
    // bus silence
    // -----------------------------------------------------------
    if (edge_seen) begin
      next_st.silence_cnt = 32'h0000_0000;
      next_st.evt.bus_idle = 1'b0;
      next_st.fdf_seen = 1'b0;
    end else if (st.silence_cnt < SILENCE_CYC - 1) begin
      next_st.silence_cnt = st.silence_cnt + 32'h0000_0001;
    end else begin
      next_st.evt.bus_idle = 1'b1;
      next_st.mode[`CDRSW_MODE_ERRDIS] = 1'b0;
    end

    // -----------------------------------------------------------
    // wake signalling
    // -----------------------------------------------------------
    if (wake_det_i) begin
      next_st.wake_pend = 1'b1;
      next_st.wake_cnt = 16'h0000;
    end else if (st.wake_pend) begin
      next_st.wake_cnt = st.wake_cnt + 16'h0001;
    end
    if (st.wake_pend) begin
      next_st.wake_pend = wake_det_i;
      next_st.evt.wake = 1'b1;
      if (st.mode[`CDRSW_MODE_STOP]) next_st.evt.interrupt_out_n = 1'b0;
      else next_st.evt.supply_on = 1'b1;
    end
    if (!next_st.evt.wake) next_st.evt.interrupt_out_n = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.rx_sync <= 2'b11;
      st.rx_prev <= 1'b0;
      st.quanta <= `CDRSW_RST_QUANTA;
      st.sample_point <= `CDRSW_RST_SAMPLE;
      st.upper <= `CDRSW_RST_UPPER;
      st.lower <= `CDRSW_RST_LOWER;
      st.bit_cyc <= 16'(`CDRSW_BIT_MIN_CYC);
      st.rsp.waitrequest <= 1'b1;
      st.evt.interrupt_out_n <= 1'b1;
      st.evt.supply_on <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rsp_o = st.rsp;
  assign interrupt_out_n_o = st.evt.interrupt_out_n;
  assign supply_on_o = st.evt.supply_on;
  assign bus_idle_o = st.evt.bus_idle;
  assign bit_cyc_o = st.bit_cyc;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_wake_react: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.wake_pend) |-> ##[1:3] st.evt.wake)
    else $error("wake not flagged in time");
  a_stop_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    st.wake_pend && st.mode[`CDRSW_MODE_STOP] |=> !interrupt_out_n_o)
    else $error("interrupt not asserted in stop");
  a_limit_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ctrl_a[0] && st.bit_cyc >= base_bit(st.upper, st.osc_clock_select)
    && base_bit(st.quanta, st.osc_clock_select) >= 16'd100
    |=> st.bit_cyc == $past(base_bit(st.quanta, st.osc_clock_select)))
    else $error("limit did not reload quanta");
  a_silence_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    st.silence_cnt == SILENCE_CYC - 1 && !edge_seen_w |=> bus_idle_o)
    else $error("silence timeout not flagged");
  a_silence_errdis: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(bus_idle_o) |-> !st.mode[5])
    else $error("error counter disable kept");
  a_bit_min: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 bit_cyc_o >= 16'd100)
    else $error("bit length below minimum");
  a_fd_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.mode[4] |-> !fd_active)
    else $error("fd_glitch_filter used without receiver select");
  a_sample_rst: assert property (@(posedge clk_i)
    $fell(rst_i) |-> st.sample_point == 6'h33)
    else $error("sample point reset value wrong");
  a_disabled_base: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.ctrl_a[0] && $stable(st.quanta) && $stable(st.osc_clock_select)
    ##1 !st.ctrl_a[0] |-> bit_cyc_o == base_bit(st.quanta,
    st.osc_clock_select) || bit_cyc_o == 16'd100)
    else $error("disabled recovery not at base");

  assign edge_seen_w = (fd_active ? dom_q : ~st.rx_sync[1]) ^ st.rx_prev;
endmodule
`default_nettype wire

// >>> dv/cdrsw_can_line.sv
// can line model: toggles rx with a set bit length while a frame runs
// assumes the bench raises run_i only for frames; idle line is recessive
`timescale 1ns/1ps
`default_nettype none
module cdrsw_can_line (
  input wire logic clk_i, // clock
  input wire logic run_i, // frame active
  input wire logic [15:0] bit_i, // bit length in cycles
  output logic rx_o // rx level, high recessive
);
  logic [15:0] cnt;
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      cnt <= 16'h0000;
      rx_o <= 1'b1; // released bus is pulled recessive
    end else if (cnt + 16'h0001 >= bit_i) begin
      cnt <= 16'h0000;
      rx_o <= ~rx_o;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the clock recovery block
// assumes cdrsw_defs.svh offsets and a short silence count
`timescale 1ns/1ps
`default_nettype none
`include "cdrsw_defs.svh"
module testbench;
  import cdrsw_pkg::*;
  localparam int SIL = 200;
  logic clk_i, rst_i, wake_det_i, fdf_det_i, run, rx, dom_in;
  logic interrupt_out_n_o, supply_on_o, bus_idle_o;
  logic [15:0] bit_cyc_o, line_bit;
  cdrsw_req_t req;
  cdrsw_rsp_t rsp;
  logic [31:0] rd, q;
  int fail_count, total_checks, cyc, n;

  cdrsw_top #(.SILENCE_CYC(SIL)) cdrsw_top_inst (.clk_i(clk_i),
    .rst_i(rst_i), .req_i(req), .rsp_o(rsp), .rx_i(rx & ~dom_in),
    .wake_det_i(wake_det_i), .fdf_det_i(fdf_det_i),
    .interrupt_out_n_o(interrupt_out_n_o), .supply_on_o(supply_on_o),
    .bus_idle_o(bus_idle_o), .bit_cyc_o(bit_cyc_o));
  cdrsw_can_line cdrsw_can_line_inst (.clk_i(clk_i), .run_i(run),
    .bit_i(line_bit), .rx_o(rx));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // avalon access: hold until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge clk_i);
      k++;
    end while (rsp.waitrequest !== 1'b0 && k < 50);
    chk(k < 50, 1'b1);
    rd = rsp.readdata;
    req <= '{address: a, read: 1'b0, write: 1'b0, writedata: d};
    @(posedge clk_i);
  endtask

  function automatic logic [15:0] base_len(input logic [7:0] qq,
                                           input logic [1:0] s);
    logic [15:0] b;
    b = {8'h00, qq} << s;
    return (b < 16'h0064) ? 16'h0064 : b;
  endfunction

  // cycles of a percentage (tenths) of the arbitration bit
  function automatic int frac(input int len, input int pm);
    return (len * pm) / 1000;
  endfunction

  // dominant pulse on the pin from an idle bus; a kept pulse ends idle
  task automatic pulse(input int len, input logic exp);
    int w;
    w = 0;
    while (bus_idle_o !== 1'b1 && w < 400) begin
      @(posedge clk_i);
      w++;
    end
    chk(bus_idle_o, 1'b1);
    dom_in <= 1'b1;
    repeat (len) @(posedge clk_i);
    dom_in <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(bus_idle_o, !exp);
  endtask

  task automatic wake_pulse();
    wake_det_i <= 1'b1;
    @(posedge clk_i);
    wake_det_i <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wake_det_i = 1'b0;
    fdf_det_i = 1'b0;
    run = 1'b0;
    dom_in = 1'b0;
    line_bit = 16'h0064;
    req = '0;
    fail_count = 0;
    total_checks = 0;
    cyc = 0;
    void'($urandom(75));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, `CDRSW_OFS_QUANTA, 0);
    chk(rd, 32'h0000_000a);
    bus(0, `CDRSW_OFS_SAMPLE, 0);
    chk(rd, 32'h0000_0033);
    bus(0, `CDRSW_OFS_UPPER, 0);
    chk(rd, 32'h0000_000c);
    bus(0, `CDRSW_OFS_LOWER, 0);
    chk(rd, 32'h0000_0008);
    bus(1, 8'h24, 32'hffff_ffff);
    bus(0, 8'h24, 0);
    chk(rd, 32'h0000_0000);
    chk({16'h0000, bit_cyc_o}, 32'h0000_0064);
    for (int s = 0; s < 4; s++) begin
      q = 32'h0000_0064 + ($urandom % 100);
      bus(1, `CDRSW_OFS_MODE, 32'h0000_0000);
      bus(1, `CDRSW_OFS_CTRL_B, s);
      bus(1, `CDRSW_OFS_QUANTA, q);
      bus(1, `CDRSW_OFS_UPPER, 32'h0000_00ff);
      bus(1, `CDRSW_OFS_LOWER, 32'h0000_0001);
      bus(0, `CDRSW_OFS_BITTIME, 0);
      chk(rd, {16'h0000, base_len(q[7:0], s[1:0])});
    end
    bus(1, `CDRSW_OFS_CTRL_B, 0);
    bus(1, `CDRSW_OFS_QUANTA, q);
    bus(1, `CDRSW_OFS_CTRL_A, {29'h0, 2'($urandom), 1'b1});
    line_bit = q[15:0] + 16'h0014;
    run <= 1'b1;
    repeat (10 * line_bit) @(posedge clk_i);
    chk(bit_cyc_o > q[15:0], 1'b1);
    bus(1, `CDRSW_OFS_CTRL_A, 0);
    bus(1, `CDRSW_OFS_UPPER, q + 1);
    bus(1, `CDRSW_OFS_LOWER, q - 1);
    bus(1, `CDRSW_OFS_STATUS, 32'h0000_0008);
    bus(1, `CDRSW_OFS_CTRL_A, 32'h0000_0001);
    repeat (6 * line_bit) @(posedge clk_i);
    run <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({16'h0000, bit_cyc_o}, q);
    bus(0, `CDRSW_OFS_STATUS, 0);
    chk(rd[3], 1'b1);
    bus(1, `CDRSW_OFS_MODE, 32'h0000_0020);
    run <= 1'b1;
    repeat (2 * line_bit) @(posedge clk_i);
    while (rx !== 1'b0) @(posedge clk_i);
    run <= 1'b0;
    n = 0;
    repeat (3) @(posedge clk_i);
    while (bus_idle_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk(n >= SIL - 8 && n <= SIL + 8, 1'b1);
    bus(0, `CDRSW_OFS_MODE, 0);
    chk(rd[5], 1'b0);
    bus(0, `CDRSW_OFS_STATUS, 0);
    chk(rd[1], 1'b1);
    run <= 1'b1;
    repeat (line_bit + 16'h0008) @(posedge clk_i);
    chk(bus_idle_o, 1'b0);
    run <= 1'b0;
    bus(1, `CDRSW_OFS_MODE, 32'h0000_0080);
    wake_pulse();
    n = 0;
    while (interrupt_out_n_o !== 1'b0 && n < `CDRSW_WAKE_CYC) begin
      @(posedge clk_i);
      n++;
    end
    chk(interrupt_out_n_o, 1'b0);
    bus(0, `CDRSW_OFS_STATUS, 0);
    chk(rd[0], 1'b1);
    bus(1, `CDRSW_OFS_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk(interrupt_out_n_o, 1'b1);
    bus(1, `CDRSW_OFS_MODE, 32'h0000_0000);
    wake_pulse();
    repeat (4) @(posedge clk_i);
    chk(supply_on_o, 1'b1);
    chk(interrupt_out_n_o, 1'b1);
    bus(1, `CDRSW_OFS_MODE, 32'h0000_0018);
    fdf_det_i <= 1'b1;
    @(posedge clk_i);
    fdf_det_i <= 1'b0;
    bus(0, `CDRSW_OFS_STATUS, 0);
    chk(rd[2], 1'b1);
    bus(1, `CDRSW_OFS_STATUS, 32'h0000_0004);
    bus(1, `CDRSW_OFS_CTRL_A, 0);
    pulse(frac(q, `CDRSW_GL2_PM), 1'b0);
    pulse(frac(q, `CDRSW_DOM2_PM) + 2, 1'b1);
    bus(1, `CDRSW_OFS_MODE, 32'h0000_0058);
    pulse(frac(q, `CDRSW_GL5_PM), 1'b0);
    pulse(frac(q, `CDRSW_DOM5_PM) + 2, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
